// ### logic/anx_pkg.sv
package anx_pkg;

  // management register addresses
  localparam logic [4:0] ANX_EXP_ADDR = 5'h06;
  localparam logic [4:0] ANX_NPTX_ADDR = 5'h07;

  // reset values
  localparam logic [15:0] ANX_EXP_RESET = 16'h0004;
  localparam logic [15:0] ANX_NPTX_RESET = 16'h2001;

  // expansion status field positions
  localparam int ANX_EXP_RSV_LSB = 5;
  localparam int ANX_EXP_RSV_MSB = 15;
  localparam int ANX_EXP_FAULT_BIT = 4;
  localparam int ANX_EXP_LPNP_BIT = 3;
  localparam int ANX_EXP_LOCAL_BIT = 2;
  localparam int ANX_EXP_PAGE_BIT = 1;
  localparam int ANX_EXP_LPAN_BIT = 0;

  // next-page transmit field positions
  localparam int ANX_TX_MORE_BIT = 15;
  localparam int ANX_TX_RSV_BIT = 14;
  localparam int ANX_TX_MSG_BIT = 13;
  localparam int ANX_TX_COMPLY_BIT = 12;
  localparam int ANX_TX_ALT_BIT = 11;
  localparam int ANX_TX_CODE_MSB = 10;
  localparam int ANX_TX_CODE_LSB = 0;

  // bits of the next-page word that management may write
  localparam logic [15:0] ANX_NPTX_WR_MASK = 16'hb7ff;

  // management register access, one request per cycle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } anx_mgmt_req_t;

  // read answer
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } anx_mgmt_rsp_t;

  // status from the negotiation engine, same clock
  typedef struct packed {
    logic parallelFault;
    logic pageGot;
    logic partnerPagesAble;
    logic partnerAnAble;
    logic localPagesAble;
  } anx_neg_status_t;

  function automatic logic anx_hit(input anx_mgmt_req_t req, input logic [4:0] addr);
    anx_hit = (req.addr == addr);
  endfunction : anx_hit

endpackage : anx_pkg

// ### logic/anx_latch_bit.sv
`timescale 1ns/1ps

module anx_latch_bit (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // event and clear
  input wire logic setPulse,
  input wire logic clearPulse,
  // latched flag
  output logic flag_r
);

  logic flag_nxt;

  // set beats a clear in the same cycle
  always_comb begin
    flag_nxt = flag_r;
    if (clearPulse) begin
      flag_nxt = 1'b0;
    end
    if (setPulse) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

endmodule : anx_latch_bit

// ### logic/anx_regs.sv
`timescale 1ns/1ps

// Summary of operation
// - A 16-bit read-only expansion status register reports partner negotiation status, reset 0004h.
// - Expansion bits 15..5 are reserved, ignore writes and read back as zero.
// - Expansion bit 4 latches on a parallel detection fault and clears when the register is read.
// - Expansion bit 1 latches when a new page arrives and clears when the register is read.
// - Expansion bit 3 shows whether the link partner can exchange next pages.
// - Expansion bit 2 shows whether the local device can exchange next pages, set out of reset.
// - Expansion bit 0 shows whether the link partner can auto-negotiate.
// - The next-page transmit register holds the next-page code word sent to the partner.
// - The next-page transmit register resets to 2001h, a message page with the null message.
// - Transmit bit 15 is writable and says whether further next pages follow.
// - Transmit bit 14 is reserved, ignores writes and reads as zero.
// - Transmit bit 13 is writable and selects message page or unformatted page.
// - Transmit bit 12 is writable and says whether the local device will comply.
// - Transmit bit 11 is read-only and is the complement of the previously sent toggle bit.
// - Transmit bits 10..0 are a writable code field for the message or unformatted code.

module anx_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // management register port
  input wire anx_pkg::anx_mgmt_req_t mgmtReq,
  output anx_pkg::anx_mgmt_rsp_t mgmtRsp_r,
  // negotiation engine
  input wire anx_pkg::anx_neg_status_t negStatus,
  input wire logic pageSent,
  output logic [15:0] txWord_r
);

  import anx_pkg::*;

  logic expRd;
  logic nptxRd;
  logic nptxWr;
  logic faultFlag_r;
  logic pageFlag_r;
  logic partnerPages_r;
  logic partnerAn_r;
  logic localPages_r;
  logic [15:0] expWord;
  logic [15:0] txWord_nxt;
  anx_mgmt_rsp_t mgmtRsp_nxt;

  // address decode
  always_comb begin
    expRd = mgmtReq.rd && anx_hit(mgmtReq, ANX_EXP_ADDR);
    nptxRd = mgmtReq.rd && anx_hit(mgmtReq, ANX_NPTX_ADDR);
    nptxWr = mgmtReq.wr && anx_hit(mgmtReq, ANX_NPTX_ADDR);
  end

  // latch-high fault indication
  anx_latch_bit u_fault_latch (
    .clk(clk),
    .rstn(rstn),
    .setPulse(negStatus.parallelFault),
    .clearPulse(expRd),
    .flag_r(faultFlag_r)
  );

  // latch-high page received indication
  anx_latch_bit u_page_latch (
    .clk(clk),
    .rstn(rstn),
    .setPulse(negStatus.pageGot),
    .clearPulse(expRd),
    .flag_r(pageFlag_r)
  );

  // capability levels, reset value gives 0004h
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      partnerPages_r <= ANX_EXP_RESET[ANX_EXP_LPNP_BIT];
      partnerAn_r <= ANX_EXP_RESET[ANX_EXP_LPAN_BIT];
      localPages_r <= ANX_EXP_RESET[ANX_EXP_LOCAL_BIT];
    end else begin
      partnerPages_r <= negStatus.partnerPagesAble;
      partnerAn_r <= negStatus.partnerAnAble;
      localPages_r <= negStatus.localPagesAble;
    end
  end

  // expansion word; writes to it are dropped
  always_comb begin
    expWord = 16'h0000;
    expWord[ANX_EXP_FAULT_BIT] = faultFlag_r;
    expWord[ANX_EXP_LPNP_BIT] = partnerPages_r;
    expWord[ANX_EXP_LOCAL_BIT] = localPages_r;
    expWord[ANX_EXP_PAGE_BIT] = pageFlag_r;
    expWord[ANX_EXP_LPAN_BIT] = partnerAn_r;
  end

  // next-page word: write masked fields, toggle only on a sent page
  always_comb begin
    txWord_nxt = txWord_r;
    if (nptxWr) begin
      txWord_nxt = (txWord_r & ~ANX_NPTX_WR_MASK)
        | (mgmtReq.wdata & ANX_NPTX_WR_MASK);
    end
    txWord_nxt[ANX_TX_RSV_BIT] = 1'b0;
    if (pageSent) begin
      txWord_nxt[ANX_TX_ALT_BIT] = ~txWord_r[ANX_TX_ALT_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txWord_r <= ANX_NPTX_RESET;
    end else begin
      txWord_r <= txWord_nxt;
    end
  end

  // read answer one cycle after the request, zero for foreign addresses
  always_comb begin
    mgmtRsp_nxt.valid = mgmtReq.rd;
    mgmtRsp_nxt.data = 16'h0000;
    if (expRd) begin
      mgmtRsp_nxt.data = expWord;
    end else if (nptxRd) begin
      mgmtRsp_nxt.data = txWord_r;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mgmtRsp_r <= '0;
    end else begin
      mgmtRsp_r <= mgmtRsp_nxt;
    end
  end

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rstn);

  sequence expReadSeq;
    mgmtReq.rd && (mgmtReq.addr == ANX_EXP_ADDR);
  endsequence

  sequence nptxReadSeq;
    mgmtReq.rd && (mgmtReq.addr == ANX_NPTX_ADDR);
  endsequence

  sequence nptxWriteSeq;
    mgmtReq.wr && (mgmtReq.addr == ANX_NPTX_ADDR) && !pageSent;
  endsequence

  sequence faultThenQuiet;
    negStatus.parallelFault ##1 (!expRd)[*3];
  endsequence

  sequence pageThenQuiet;
    negStatus.pageGot ##1 (!expRd)[*3];
  endsequence

  sequence expWriteSeq;
    mgmtReq.wr && !mgmtReq.rd && (mgmtReq.addr == ANX_EXP_ADDR)
      && !negStatus.parallelFault && !negStatus.pageGot;
  endsequence

  sequence foreignReadSeq;
    mgmtReq.rd && (mgmtReq.addr != ANX_EXP_ADDR) && (mgmtReq.addr != ANX_NPTX_ADDR);
  endsequence

  sequence foreignWriteSeq;
    mgmtReq.wr && (mgmtReq.addr != ANX_NPTX_ADDR) && !pageSent;
  endsequence

  sequence writeWithPageSeq;
    mgmtReq.wr && (mgmtReq.addr == ANX_NPTX_ADDR) && pageSent;
  endsequence

  sequence pageTwiceSeq;
    pageSent ##1 pageSent;
  endsequence

  sequence txQuietSeq;
    !(mgmtReq.wr && (mgmtReq.addr == ANX_NPTX_ADDR)) && !pageSent;
  endsequence

  exp_reserved_a: assert property (
    expReadSeq |=> mgmtRsp_r.valid && (mgmtRsp_r.data[ANX_EXP_RSV_MSB:ANX_EXP_RSV_LSB] == 11'h000))
    else $error("expansion reserved bits not zero");

  fault_held_a: assert property (
    faultThenQuiet |=> faultFlag_r)
    else $error("fault flag lost before read");

  fault_clear_a: assert property (
    expReadSeq ##0 !negStatus.parallelFault |=> !faultFlag_r
      ##0 (mgmtRsp_r.data[ANX_EXP_FAULT_BIT] == $past(faultFlag_r)))
    else $error("fault flag not cleared by read");

  fault_wins_a: assert property (
    expReadSeq ##0 negStatus.parallelFault |=> faultFlag_r)
    else $error("fault event lost on clearing read");

  page_held_a: assert property (
    pageThenQuiet |=> pageFlag_r)
    else $error("page flag lost before read");

  page_clear_a: assert property (
    expReadSeq ##0 !negStatus.pageGot |=> !pageFlag_r
      ##0 (mgmtRsp_r.data[ANX_EXP_PAGE_BIT] == $past(pageFlag_r)))
    else $error("page flag not cleared by read");

  capability_bits_a: assert property (
    expReadSeq |=> (mgmtRsp_r.data[ANX_EXP_LPNP_BIT] == $past(negStatus.partnerPagesAble, 2))
      && (mgmtRsp_r.data[ANX_EXP_LOCAL_BIT] == $past(negStatus.localPagesAble, 2))
      && (mgmtRsp_r.data[ANX_EXP_LPAN_BIT] == $past(negStatus.partnerAnAble, 2)))
    else $error("capability bits do not follow engine");

  nptx_write_a: assert property (
    nptxWriteSeq |=> ((txWord_r & ANX_NPTX_WR_MASK) == ($past(mgmtReq.wdata) & ANX_NPTX_WR_MASK))
      && (txWord_r[ANX_TX_ALT_BIT] == $past(txWord_r[ANX_TX_ALT_BIT])))
    else $error("next-page write not stored");

  nptx_reserved_a: assert property (
    nptxReadSeq |=> !mgmtRsp_r.data[ANX_TX_RSV_BIT] && !txWord_r[ANX_TX_RSV_BIT])
    else $error("next-page reserved bit set");

  toggle_flip_a: assert property (
    pageSent |=> txWord_r[ANX_TX_ALT_BIT] != $past(txWord_r[ANX_TX_ALT_BIT]))
    else $error("toggle did not invert after page");

  toggle_still_a: assert property (
    !pageSent |=> $stable(txWord_r[ANX_TX_ALT_BIT]))
    else $error("toggle changed without a sent page");

  nptx_readback_a: assert property (
    nptxReadSeq |=> mgmtRsp_r.valid && (mgmtRsp_r.data == $past(txWord_r)))
    else $error("next-page readback mismatch");

  page_wins_a: assert property (
    expReadSeq ##0 negStatus.pageGot |=> pageFlag_r)
    else $error("page event lost on clearing read");

  fault_set_a: assert property (
    negStatus.parallelFault |=> faultFlag_r)
    else $error("fault flag not set by event");

  page_set_a: assert property (
    negStatus.pageGot |=> pageFlag_r)
    else $error("page flag not set by event");

  fault_quiet_a: assert property (
    !negStatus.parallelFault && !faultFlag_r |=> !faultFlag_r)
    else $error("fault flag rose without event");

  page_quiet_a: assert property (
    !negStatus.pageGot && !pageFlag_r |=> !pageFlag_r)
    else $error("page flag rose without event");

  flags_cleared_a: assert property (
    expReadSeq ##0 !negStatus.parallelFault ##0 !negStatus.pageGot |=> !faultFlag_r && !pageFlag_r)
    else $error("read left a latched flag set");

  read_valid_a: assert property (
    mgmtReq.rd |=> mgmtRsp_r.valid)
    else $error("read got no answer");

  idle_quiet_a: assert property (
    !mgmtReq.rd |=> !mgmtRsp_r.valid && (mgmtRsp_r.data == 16'h0000))
    else $error("answer without a read");

  exp_valid_a: assert property (
    expReadSeq |=> mgmtRsp_r.valid)
    else $error("expansion read got no answer");

  foreign_read_a: assert property (
    foreignReadSeq |=> mgmtRsp_r.valid && (mgmtRsp_r.data == 16'h0000))
    else $error("foreign read data not zero");

  exp_write_a: assert property (
    expWriteSeq |=> $stable(faultFlag_r) && $stable(pageFlag_r))
    else $error("write to expansion changed it");

  foreign_write_a: assert property (
    foreignWriteSeq |=> $stable(txWord_r))
    else $error("foreign write changed next page word");

  tx_hold_a: assert property (
    txQuietSeq |=> $stable(txWord_r))
    else $error("next page word changed while idle");

  write_page_a: assert property (
    writeWithPageSeq |=>
      ((txWord_r & ANX_NPTX_WR_MASK) == ($past(mgmtReq.wdata) & ANX_NPTX_WR_MASK))
      && (txWord_r[ANX_TX_ALT_BIT] != $past(txWord_r[ANX_TX_ALT_BIT])))
    else $error("write with sent page mishandled");

  tx_reserved_a: assert property (
    !txWord_r[ANX_TX_RSV_BIT])
    else $error("reserved transmit bit set");

  rsv_write_ignored_a: assert property (
    nptxWriteSeq |=> !txWord_r[ANX_TX_RSV_BIT])
    else $error("reserved transmit bit written");

  toggle_write_a: assert property (
    nptxWriteSeq |=> txWord_r[ANX_TX_ALT_BIT] == $past(txWord_r[ANX_TX_ALT_BIT]))
    else $error("toggle taken from a write");

  toggle_twice_a: assert property (
    pageTwiceSeq |=> txWord_r[ANX_TX_ALT_BIT] == $past(txWord_r[ANX_TX_ALT_BIT], 2))
    else $error("toggle did not alternate");

  caps_follow_a: assert property (
    1'b1 |=> (partnerPages_r == $past(negStatus.partnerPagesAble))
      && (localPages_r == $past(negStatus.localPagesAble))
      && (partnerAn_r == $past(negStatus.partnerAnAble)))
    else $error("capability flops do not follow engine");

  partner_pages_read_a: assert property (
    expReadSeq |=> mgmtRsp_r.data[ANX_EXP_LPNP_BIT] == $past(partnerPages_r))
    else $error("partner page ability misread");

  local_pages_read_a: assert property (
    expReadSeq |=> mgmtRsp_r.data[ANX_EXP_LOCAL_BIT] == $past(localPages_r))
    else $error("local page ability misread");

  partner_an_read_a: assert property (
    expReadSeq |=> mgmtRsp_r.data[ANX_EXP_LPAN_BIT] == $past(partnerAn_r))
    else $error("partner negotiation ability misread");

  code_field_a: assert property (
    nptxWriteSeq |=> txWord_r[ANX_TX_CODE_MSB:ANX_TX_CODE_LSB]
      == $past(mgmtReq.wdata[ANX_TX_CODE_MSB:ANX_TX_CODE_LSB]))
    else $error("code field not stored");

  more_pages_a: assert property (
    nptxWriteSeq |=> txWord_r[ANX_TX_MORE_BIT] == $past(mgmtReq.wdata[ANX_TX_MORE_BIT]))
    else $error("more pages bit not stored");

  page_type_a: assert property (
    nptxWriteSeq |=> txWord_r[ANX_TX_MSG_BIT] == $past(mgmtReq.wdata[ANX_TX_MSG_BIT]))
    else $error("page type bit not stored");

  comply_bit_a: assert property (
    nptxWriteSeq |=> txWord_r[ANX_TX_COMPLY_BIT] == $past(mgmtReq.wdata[ANX_TX_COMPLY_BIT]))
    else $error("comply bit not stored");

endmodule : anx_regs

// ### testbench/anx_mgmt_model.sv
`timescale 1ns/1ps

module anx_mgmt_model (
  // clock
  input wire logic clk,
  // register port
  output anx_pkg::anx_mgmt_req_t req,
  input wire anx_pkg::anx_mgmt_rsp_t rsp
);
  import anx_pkg::*;

  initial req = '0;

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{1'b0, 1'b1, a, d};
    @(negedge clk);
    req = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, 16'h0000};
    d = 16'hdead;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      req = '{1'b0, 1'b0, ~a, 16'hffff};
      if (rsp.valid === 1'b1) begin
        d = rsp.data;
        break;
      end
    end
  endtask : rd
endmodule : anx_mgmt_model

// ### testbench/test_anx_regs.sv
`timescale 1ns/1ps

module test_anx_regs;
  import anx_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  anx_mgmt_req_t mgmtReq;
  anx_mgmt_rsp_t mgmtRsp;
  anx_neg_status_t negStatus = 5'h01;
  logic pageSent = 1'b0;
  logic [15:0] txWord;
  logic [15:0] rdat;
  int fails = 0;
  int checks = 0;

  always #5 clk = ~clk;

  anx_regs i_dut (.clk(clk), .rstn(rstn), .mgmtReq(mgmtReq), .mgmtRsp_r(mgmtRsp),
    .negStatus(negStatus), .pageSent(pageSent), .txWord_r(txWord));
  anx_mgmt_model i_mgmt (.clk(clk), .req(mgmtReq), .rsp(mgmtRsp));

  task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
    checks++;
    if (got !== expv) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, expv, got);
    end
  endtask : chk

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] expv);
    i_mgmt.rd(a, rdat);
    chk("read data", expv, rdat);
  endtask : rd_chk

  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic t_reset;
    rd_chk(ANX_EXP_ADDR, 16'h0004);
    rd_chk(ANX_NPTX_ADDR, 16'h2001);
    chk("tx word", 16'h2001, txWord);
    rd_chk(5'h1f, 16'h0000);
  endtask : t_reset

  task automatic t_caps;
    @(negedge clk);
    negStatus = 5'h06;
    repeat (2) @(negedge clk);
    rd_chk(ANX_EXP_ADDR, 16'h0009);
    negStatus = 5'h01;
    repeat (2) @(negedge clk);
    rd_chk(ANX_EXP_ADDR, 16'h0004);
  endtask : t_caps

  task automatic t_latch;
    @(negedge clk);
    negStatus = 5'h11;
    @(negedge clk);
    negStatus = 5'h09;
    @(negedge clk);
    negStatus = 5'h01;
    repeat (3) @(negedge clk);
    rd_chk(ANX_EXP_ADDR, 16'h0016);
    rd_chk(ANX_EXP_ADDR, 16'h0004);
    i_mgmt.wr(ANX_EXP_ADDR, 16'hffff);
    rd_chk(ANX_EXP_ADDR, 16'h0004);
  endtask : t_latch

  task automatic t_nptx;
    i_mgmt.wr(ANX_NPTX_ADDR, 16'hffff);
    rd_chk(ANX_NPTX_ADDR, 16'hb7ff);
    i_mgmt.wr(ANX_NPTX_ADDR, 16'h4800);
    rd_chk(ANX_NPTX_ADDR, 16'h0000);
    chk("tx word", 16'h0000, txWord);
  endtask : t_nptx

  task automatic t_toggle;
    @(negedge clk);
    pageSent = 1'b1;
    @(negedge clk);
    pageSent = 1'b0;
    chk("tx word", 16'h0800, txWord);
    @(negedge clk);
    pageSent = 1'b1;
    repeat (2) @(negedge clk);
    pageSent = 1'b0;
    rd_chk(ANX_NPTX_ADDR, 16'h0800);
    i_mgmt.wr(ANX_NPTX_ADDR, 16'h0000);
    rd_chk(ANX_NPTX_ADDR, 16'h0800);
  endtask : t_toggle

  task automatic t_write_page;
    fork
      i_mgmt.wr(ANX_NPTX_ADDR, 16'h2005);
      begin
        @(negedge clk);
        pageSent = 1'b1;
        @(negedge clk);
        pageSent = 1'b0;
      end
    join
    rd_chk(ANX_NPTX_ADDR, 16'h2005);
  endtask : t_write_page

  task automatic t_midreset;
    @(negedge clk);
    negStatus = 5'h11;
    @(negedge clk);
    negStatus = 5'h01;
    rstn = 1'b0;
    @(negedge clk);
    chk("tx word", 16'h2001, txWord);
    chk("answer data", 16'h0000, mgmtRsp.data);
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    rd_chk(ANX_EXP_ADDR, 16'h0004);
    rd_chk(ANX_NPTX_ADDR, 16'h2001);
  endtask : t_midreset

  initial begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_caps();
    t_latch();
    t_nptx();
    t_toggle();
    t_write_page();
    t_midreset();
    end_of_test();
  end

  initial begin
    #100000;
    fails++;
    end_of_test();
  end
endmodule : test_anx_regs
